//--- rtl/dai_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// delta angle / delta velocity integrator.
// Assumes a 10 MHz system clock and byte addressing of 16-bit registers.
`ifndef DAI_CFG_SVH
`define DAI_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses (each register spans an even/odd byte pair)
// ----------------------------------------------------------------------
`define DAI_ADDR_W 7
`define DAI_ADDR_Z_ANG_LOW 7'h2c
`define DAI_ADDR_Z_ANG_HIGH 7'h2e
`define DAI_ADDR_X_SPD_LOW 7'h30
`define DAI_ADDR_X_SPD_HIGH 7'h32
`define DAI_ADDR_Y_SPD_LOW 7'h34
`define DAI_ADDR_Y_SPD_HIGH 7'h36

// ----------------------------------------------------------------------
// Field layout of one 32-bit result split into two 16-bit words
// ----------------------------------------------------------------------
`define DAI_WORD_W 16
`define DAI_RES_W 32
`define DAI_HIGH_MSB 31
`define DAI_HIGH_LSB 16
`define DAI_LOW_MSB 15
`define DAI_LOW_LSB 0
`define DAI_ACC_W 50
`define DAI_WORD_RESET 16'h0000
`define DAI_DEC_RESET 16'h0000

// ----------------------------------------------------------------------
// Timing: internal sample clock derived from the system clock
// ----------------------------------------------------------------------
`define DAI_CLK_HZ 10000000
`define DAI_SAMPLE_SPS 2000
`define DAI_SAMPLE_DIV (`DAI_CLK_HZ / `DAI_SAMPLE_SPS)
`define DAI_DIV_W 16

`endif

//--- rtl/dai_pkg.sv
// Types shared by the delta angle / delta velocity integrator.
// Assumes dai_cfg.svh is on the include path.
`include "dai_cfg.svh"

package dai_pkg;

  // One set of sensor samples, each pre-scaled so that one sample LSB
  // equals one output LSB accumulated over one sample interval.
  typedef struct packed {
    logic signed [`DAI_RES_W-1:0] gyro_z;
    logic signed [`DAI_RES_W-1:0] accel_x;
    logic signed [`DAI_RES_W-1:0] accel_y;
  } dai_samples_s;

  // Register read request.
  typedef struct packed {
    logic en;
    logic [`DAI_ADDR_W-1:0] addr;
  } dai_rd_req_s;

  // Phase within one decimation period.
  typedef enum logic [1:0] {
    DAI_ST_FIRST = 2'b01,
    DAI_ST_ACCUM = 2'b10
  } dai_phase_e;

  // Clamps a wide accumulator value into the 32-bit result range.
  function automatic logic [`DAI_RES_W-1:0] dai_sat(input logic signed [`DAI_ACC_W-1:0] v);
    logic signed [`DAI_ACC_W-1:0] hi;
    logic signed [`DAI_ACC_W-1:0] lo;
    hi = `DAI_ACC_W'(32'sh7fffffff);
    lo = -hi - `DAI_ACC_W'(1);
    if (v > hi) begin
      dai_sat = 32'h7fffffff;
    end else if (v < lo) begin
      dai_sat = 32'h80000000;
    end else begin
      dai_sat = v[`DAI_RES_W-1:0];
    end
  endfunction

endpackage

//--- rtl/dai_trap_acc.sv
// One channel of trapezoidal integration over a decimation period.
// Assumes first/last are qualified by smp_en and framed by the caller.
`timescale 1ns/100ps

`include "dai_cfg.svh"

module dai_trap_acc
  import dai_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream and period framing
  input wire logic smp_en,
  input wire logic first,
  input wire logic last,
  input wire logic signed [`DAI_RES_W-1:0] smp,
  // Result
  output logic [`DAI_RES_W-1:0] result,
  output logic done,
  output logic clipped
);

  logic signed [`DAI_RES_W-1:0] prev;
  logic signed [`DAI_ACC_W-1:0] acc;
  logic signed [`DAI_ACC_W-1:0] pair;
  logic signed [`DAI_ACC_W-1:0] next_acc;
  logic signed [`DAI_ACC_W-1:0] half;

  // ----------------------------------------------------------------------
  // Pair sum and running total
  // ----------------------------------------------------------------------

  // Each sample is added to the one before it; the first pair of a period
  // reaches back to the last sample of the previous period.
  always_comb begin
    pair = `DAI_ACC_W'(smp) + `DAI_ACC_W'(prev);
    next_acc = first ? pair : acc + pair;
    half = next_acc >>> 1; // Division by two of the trapezoid.
  end

  // Keeps the previous sample and the running sum.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= '0;
      acc <= '0;
    end else if (smp_en) begin
      prev <= smp;
      acc <= next_acc;
    end
  end

  // ----------------------------------------------------------------------
  // Period result
  // ----------------------------------------------------------------------

  // Closes the period: scales, clamps and flags the result.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= '0;
      done <= 1'b0;
      clipped <= 1'b0;
    end else begin
      done <= smp_en & last;
      if (smp_en && last) begin
        result <= dai_sat(half);
        // Compares at full width: a clamped value may share its low bits with the sum.
        clipped <= (`DAI_ACC_W'($signed(dai_sat(half))) != half);
      end
    end
  end

endmodule // dai_trap_acc

//--- rtl/dai_integrator.sv
// Delta angle (z) and delta velocity (x, y) integrator with its output
// registers and register read port.
// Assumes sensor samples, strobes and read requests are synchronous to clk.
`timescale 1ns/100ps

`include "dai_cfg.svh"

module dai_integrator
  import dai_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `DAI_SAMPLE_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sensor sample source
  input wire dai_samples_s smp_in,
  input wire logic use_ext_clock,
  input wire logic ext_sample_strobe,
  // Configuration
  input wire logic [`DAI_WORD_W-1:0] decimation_setting,
  // Register read port
  input wire dai_rd_req_s rd_req,
  output logic [`DAI_WORD_W-1:0] rd_data,
  output logic rd_valid,
  // Status
  output logic data_ready_pin,
  output logic [`DAI_WORD_W-1:0] update_count,
  output logic clip_flag
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  // Sample clock and capture.
  logic [`DAI_DIV_W-1:0] div_cnt;
  logic int_tick;
  logic smp_tick;
  logic smp_en;
  dai_samples_s smp_hold;

  // Period framing.
  dai_phase_e phase;
  logic [`DAI_WORD_W-1:0] dec_hold;
  logic [`DAI_WORD_W-1:0] cnt;
  logic first;
  logic last;

  // Channel results and output words.
  logic [`DAI_RES_W-1:0] res_ang_z;
  logic [`DAI_RES_W-1:0] res_spd_x;
  logic [`DAI_RES_W-1:0] res_spd_y;
  logic [2:0] done;
  logic [2:0] clipped;
  logic [`DAI_RES_W-1:0] out_ang_z;
  logic [`DAI_RES_W-1:0] out_spd_x;
  logic [`DAI_RES_W-1:0] out_spd_y;

  // Read port.
  logic [`DAI_WORD_W-1:0] next_rd_data;

  localparam logic [`DAI_DIV_W-1:0] DIV_LAST = `DAI_DIV_W'(SAMPLE_DIV - 1);

  // ----------------------------------------------------------------------
  // Word selection
  // ----------------------------------------------------------------------

  // Upper half of a result; it keeps the sign, so it stands alone as a
  // 16-bit two's complement value.
  function automatic logic [`DAI_WORD_W-1:0] dai_high_word(input logic [`DAI_RES_W-1:0] v);
    dai_high_word = v[`DAI_HIGH_MSB:`DAI_HIGH_LSB];
  endfunction

  // Lower half of a result: the extra resolution bits below the upper half.
  function automatic logic [`DAI_WORD_W-1:0] dai_low_word(input logic [`DAI_RES_W-1:0] v);
    dai_low_word = v[`DAI_LOW_MSB:`DAI_LOW_LSB];
  endfunction

  // ----------------------------------------------------------------------
  // Sample clock
  // ----------------------------------------------------------------------

  // Divides the system clock down to the nominal internal sample rate.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + `DAI_DIV_W'(1);
    end
  end

  // Internal tick is a one-cycle enable at the end of each divider period.
  assign int_tick = (div_cnt == DIV_LAST);

  // Picks the internal sample clock or an external sample strobe.
  assign smp_tick = use_ext_clock ? ext_sample_strobe : int_tick;

  // ----------------------------------------------------------------------
  // Sample capture
  // ----------------------------------------------------------------------

  // Captures the undecimated sensor stream on each sample tick; the
  // integrators see it one cycle later through smp_en.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_hold <= '0;
      smp_en <= 1'b0;
    end else begin
      smp_en <= smp_tick;
      if (smp_tick) begin
        smp_hold <= smp_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decimation period framing
  // ----------------------------------------------------------------------

  // A period holds decimation_setting + 1 samples. The setting is taken at
  // the first sample of a period, so changes act from the next period on.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= DAI_ST_FIRST;
      dec_hold <= `DAI_DEC_RESET;
      cnt <= '0;
    end else if (smp_en) begin
      unique case (phase)
        DAI_ST_FIRST: begin
          dec_hold <= decimation_setting;
          cnt <= `DAI_WORD_W'(1);
          if (decimation_setting != `DAI_DEC_RESET) begin
            phase <= DAI_ST_ACCUM;
          end
        end
        DAI_ST_ACCUM: begin
          if (cnt == dec_hold) begin
            phase <= DAI_ST_FIRST;
          end else begin
            cnt <= cnt + `DAI_WORD_W'(1);
          end
        end
      endcase
    end
  end

  // First and last sample of the current period.
  always_comb begin
    first = (phase == DAI_ST_FIRST);
    if (first) begin
      last = (decimation_setting == `DAI_DEC_RESET);
    end else begin
      last = (cnt == dec_hold);
    end
  end

  // ----------------------------------------------------------------------
  // Trapezoidal integrators
  // ----------------------------------------------------------------------

  // Z-axis delta angle from the gyroscope rate.
  dai_trap_acc u_ang_z (
    .clk(clk),
    .rst_n(rst_n),
    .smp_en(smp_en),
    .first(first),
    .last(last),
    .smp(smp_hold.gyro_z),
    .result(res_ang_z),
    .done(done[0]),
    .clipped(clipped[0])
  );

  // X-axis delta velocity from the acceleration.
  dai_trap_acc u_spd_x (
    .clk(clk),
    .rst_n(rst_n),
    .smp_en(smp_en),
    .first(first),
    .last(last),
    .smp(smp_hold.accel_x),
    .result(res_spd_x),
    .done(done[1]),
    .clipped(clipped[1])
  );

  // Y-axis delta velocity from the acceleration.
  dai_trap_acc u_spd_y (
    .clk(clk),
    .rst_n(rst_n),
    .smp_en(smp_en),
    .first(first),
    .last(last),
    .smp(smp_hold.accel_y),
    .result(res_spd_y),
    .done(done[2]),
    .clipped(clipped[2])
  );

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------

  // All three channels close in the same cycle, so one pulse loads every
  // word together. Nothing latches a pair on a read, so a host that reads
  // the two words across an update can get them from two periods.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_ang_z <= '0;
      out_spd_x <= '0;
      out_spd_y <= '0;
    end else if (done[0]) begin
      out_ang_z <= res_ang_z;
      out_spd_x <= res_spd_x;
      out_spd_y <= res_spd_y;
    end
  end

  // Data ready pulse, high in the cycle in which the output words change.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_ready_pin <= 1'b0;
    end else begin
      data_ready_pin <= done[0];
    end
  end

  // Update counter, one step per update, wrapping at the top.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_count <= `DAI_WORD_RESET;
    end else if (done[0]) begin
      update_count <= update_count + `DAI_WORD_W'(1);
    end
  end

  // Clip flag, set when any channel of the latest update saturated.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clip_flag <= 1'b0;
    end else if (done[0]) begin
      clip_flag <= |clipped;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------

  // Selects the addressed word; the odd byte of a pair reads the same word
  // and unmapped addresses read as zero. High words carry the top half of
  // the 32-bit result, so they stand alone as 16-bit values.
  always_comb begin
    next_rd_data = `DAI_WORD_RESET;
    unique case ({rd_req.addr[`DAI_ADDR_W-1:1], 1'b0})
      `DAI_ADDR_Z_ANG_LOW: begin
        next_rd_data = dai_low_word(out_ang_z);
      end
      `DAI_ADDR_Z_ANG_HIGH: begin
        next_rd_data = dai_high_word(out_ang_z);
      end
      `DAI_ADDR_X_SPD_LOW: begin
        next_rd_data = dai_low_word(out_spd_x);
      end
      `DAI_ADDR_X_SPD_HIGH: begin
        next_rd_data = dai_high_word(out_spd_x);
      end
      `DAI_ADDR_Y_SPD_LOW: begin
        next_rd_data = dai_low_word(out_spd_y);
      end
      `DAI_ADDR_Y_SPD_HIGH: begin
        next_rd_data = dai_high_word(out_spd_y);
      end
      default: begin
        next_rd_data = `DAI_WORD_RESET;
      end
    endcase
  end

  // Answers a read one cycle after the request; data holds until the next.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= `DAI_WORD_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req.en;
      if (rd_req.en) begin
        rd_data <= next_rd_data;
      end
    end
  end

endmodule // dai_integrator

//--- sim/dai_integrator_sva.sv
// Port assertions for the integrator, bound into every dai_integrator.
// Assumes rst_n is held low for at least two clock edges.
`timescale 1ns/100ps

`include "dai_cfg.svh"

module dai_integrator_sva
  import dai_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `DAI_SAMPLE_DIV
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire dai_samples_s smp_in,
  input wire logic use_ext_clock,
  input wire logic ext_sample_strobe,
  input wire logic [`DAI_WORD_W-1:0] decimation_setting,
  input wire dai_rd_req_s rd_req,
  input wire logic [`DAI_WORD_W-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic data_ready_pin,
  input wire logic [`DAI_WORD_W-1:0] update_count,
  input wire logic clip_flag
);
  // ----------
  // Helpers
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic mapped;
  logic [15:0] gap;
  // Mapped words sit between the low z word and the high y word.
  assign mapped = (rd_req.addr[6:1] >= 6'h16) && (rd_req.addr[6:1] <= 6'h1b);
  // Counts cycles since the last update, saturating so a long pause stays large.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap <= 16'hffff;
    end else begin
      gap <= data_ready_pin ? 16'h0001 : ((gap == 16'hffff) ? gap : gap + 16'h0001);
    end
  end
  // ----------
  // Properties
  // ----------
  property p_rd_answer;
    rd_req.en |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet;
    !rd_req.en |=> !rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
  property p_unmapped;
    rd_req.en && !mapped |=> rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !rd_req.en |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ext_latency;
    use_ext_clock && ext_sample_strobe && decimation_setting == 16'h0000 |-> ##3 data_ready_pin;
  endproperty
  a_ext_latency: assert property (p_ext_latency) else $error("update late");
  property p_count;
    data_ready_pin |-> update_count == $past(update_count) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("count not stepped");
  property p_count_hold;
    !data_ready_pin |-> $stable(update_count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved");
  property p_int_rate;
    data_ready_pin && !use_ext_clock |-> gap >= 16'(SAMPLE_DIV);
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("internal rate too fast");
  property p_clip;
    $changed(clip_flag) |-> data_ready_pin;
  endproperty
  a_clip: assert property (p_clip) else $error("clip flag off update");
  c_internal: cover property (data_ready_pin && !use_ext_clock);
  c_clip: cover property ($rose(clip_flag));
  c_read: cover property (rd_valid && rd_data != 16'h0000);
endmodule // dai_integrator_sva

bind dai_integrator dai_integrator_sva #(.SAMPLE_DIV(SAMPLE_DIV)) u_sva (.clk(clk),
  .rst_n(rst_n), .smp_in(smp_in), .use_ext_clock(use_ext_clock),
  .ext_sample_strobe(ext_sample_strobe), .decimation_setting(decimation_setting),
  .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid), .data_ready_pin(data_ready_pin),
  .update_count(update_count), .clip_flag(clip_flag));

//--- sim/dai_host_model.sv
// Host model: issues one register read per go pulse and returns the word.
// Assumes the one-cycle read answer of the integrator.
`timescale 1ns/100ps

`include "dai_cfg.svh"

module dai_host_model
  import dai_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands from the bench
  input wire logic go,
  input wire logic [`DAI_ADDR_W-1:0] addr,
  // Register read port
  output dai_rd_req_s rd_req,
  input wire logic [`DAI_WORD_W-1:0] rd_data,
  input wire logic rd_valid,
  // Captured word
  output logic [`DAI_WORD_W-1:0] word,
  output logic got
);
  // Holds the request one cycle and keeps the word seen with the answer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_req <= '0;
      word <= 16'h0000;
      got <= 1'b0;
    end else begin
      rd_req.en <= go;
      if (go) rd_req.addr <= addr;
      if (rd_valid) word <= rd_data;
      got <= rd_valid;
    end
  end
endmodule // dai_host_model

//--- sim/delta_angle_velocity_integrator_test.sv
// Self-checking bench of the integrator; reads go through the host model.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/100ps

`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module delta_angle_velocity_integrator_test;
  import dai_pkg::*;
  // ----------
  // Signals
  // ----------
  localparam int unsigned DIV = 8;
  logic clk, rst_n, use_ext_clock, ext_sample_strobe, go, rd_valid, data_ready_pin;
  logic clip_flag, got, exp_clip, u;
  dai_samples_s smp_in;
  dai_rd_req_s rd_req;
  logic [15:0] decimation_setting, rd_data, update_count, word, exp_w, exp_cnt;
  logic [6:0] addr;
  logic [15:0] exp_q[$];
  logic [31:0] rng, res[3];
  longint prev[3], acc[3];
  int errors, comparisons, phase, per, since_dr, dr_gap;

  dai_integrator #(.SAMPLE_DIV(DIV)) dut (.clk(clk), .rst_n(rst_n), .smp_in(smp_in),
    .use_ext_clock(use_ext_clock), .ext_sample_strobe(ext_sample_strobe),
    .decimation_setting(decimation_setting), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .data_ready_pin(data_ready_pin), .update_count(update_count),
    .clip_flag(clip_flag));
  dai_host_model host (.clk(clk), .rst_n(rst_n), .go(go), .addr(addr), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .word(word), .got(got));

  // Clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Pairs each captured word with the oldest expected word, and times data ready pulses.
  always @(posedge clk) begin
    if (got === 1'b1) begin
      exp_w = exp_q.pop_front();
      `CHECK("register word", exp_w, word)
    end
    if (data_ready_pin === 1'b1) begin
      dr_gap = since_dr;
      since_dr = 1;
    end else begin
      since_dr++;
    end
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] rand32();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic dai_samples_s rnd_smp();
    return '{$signed(rand32()) >>> 6, $signed(rand32()) >>> 6, $signed(rand32()) >>> 6};
  endfunction
  task automatic finish_test();
    `CHECK("pending reads", 0, exp_q.size())
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk);
    go = 1'b1;
    addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    go = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Reads both words of every axis; odd addresses reach the same word.
  task automatic check_all();
    for (int i = 0; i < 3; i++) begin
      read_reg(7'h2c + 7'(4 * i), res[i][15:0]);
      read_reg(7'h2f + 7'(4 * i), res[i][31:16]);
    end
    `CHECK("update count", exp_cnt, update_count)
    `CHECK("clip flag", exp_clip, clip_flag)
  endtask
  // Trapezoidal sum of sample pairs; the halving is the floor shift.
  task automatic model(input dai_samples_s v, output logic upd);
    longint s[3];
    s = '{v.gyro_z, v.accel_x, v.accel_y};
    if (phase == 0) per = int'(decimation_setting) + 1;
    upd = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (phase == 0) acc[i] = 0;
      acc[i] += s[i] + prev[i];
      prev[i] = s[i];
    end
    phase++;
    if (phase == per) begin
      exp_clip = 1'b0;
      for (int i = 0; i < 3; i++) begin
        res[i] = (acc[i] >>> 1) > 64'sh7fffffff ? 32'h7fffffff :
          ((acc[i] >>> 1) < -64'sh80000000 ? 32'h80000000 : acc[i][32:1]);
        if (longint'($signed(res[i])) != (acc[i] >>> 1)) exp_clip = 1'b1;
      end
      exp_cnt++;
      phase = 0;
      upd = 1'b1;
    end
  endtask
  task automatic wait_dr();
    int n;
    n = 0;
    while (data_ready_pin !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3 * DIV) begin
        `CHECK("data ready", 1'b1, data_ready_pin)
        finish_test();
      end
    end
    @(negedge clk);
  endtask
  task automatic tick(input dai_samples_s v);
    logic upd;
    @(negedge clk);
    smp_in = v;
    ext_sample_strobe = 1'b1;
    @(negedge clk);
    ext_sample_strobe = 1'b0;
    model(v, upd);
    if (upd) wait_dr();
  endtask
  // ----------
  // Scenarios
  // ----------
  initial begin
    rst_n = 1'b0;
    use_ext_clock = 1'b1;
    ext_sample_strobe = 1'b0;
    go = 1'b0;
    addr = 7'h00;
    smp_in = '0;
    decimation_setting = 16'h0000;
    rng = 32'h00000019;
    {errors, comparisons, phase} = '0;
    exp_cnt = 16'h0000;
    exp_clip = 1'b0;
    prev = '{0, 0, 0};
    res = '{default: '0};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check_all();
    read_reg(7'h00, 16'h0000);
    read_reg(7'h38, 16'h0000);
    // Periods of one, two and three samples, random data, ticks two cycles apart.
    for (int j = 0; j < 9; j++) begin
      decimation_setting = 16'(j % 3);
      repeat (j % 3 + 1) tick(rnd_smp());
      check_all();
    end
    // Extremes saturate, then a zero sample halves the held value.
    decimation_setting = 16'h0002;
    repeat (3) tick('{32'sh7fffffff, 32'sh80000000, 32'sh00000001});
    check_all();
    decimation_setting = 16'h0000;
    tick('0);
    check_all();
    // Internal sample clock, one update per sample.
    smp_in = '{32'sh00001234, -32'sh00000777, 32'sh00000040};
    use_ext_clock = 1'b0;
    repeat (3) begin
      wait_dr();
      model(smp_in, u);
    end
    // The host measures the sample rate from the data ready period at decimation zero.
    `CHECK("data ready period", DIV, dr_gap)
    use_ext_clock = 1'b1;
    check_all();
    finish_test();
  end
endmodule // delta_angle_velocity_integrator_test
